// *** hw/clk_gen_pkg.sv ***
package clk_gen_pkg;

  // ---------------------------------------------------------------
  // I/O ports and register indexes
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_PORT   = 16'h00EC;
  localparam logic [15:0] DATA_PORT  = 16'h00ED;
  localparam logic [15:0] SLOW_PORT  = 16'h00F4;
  localparam logic [15:0] FULL_PORT  = 16'h00F5;
  localparam logic [7:0]  IDX_SPEED_REF = 8'h05;
  localparam logic [7:0]  IDX_CLK_CFG   = 8'h06;
  localparam logic [7:0]  IDX_MISC      = 8'h07;
  localparam logic [7:0]  IDX_FAST_BASE = 8'h0B;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int FAST_EN_BIT    = 7;
  localparam int CPU_DIV_LO     = 5;
  localparam int FAST_DIV_LO    = 3;
  localparam int SENSE_BIT      = 2;
  localparam int SLOW_DIV_LO    = 0;
  localparam int SPEED_SW_BIT   = 4;
  localparam int SOFT_SPEED_BIT = 7;
  localparam logic [7:0] CLK_CFG_RST   = 8'h1B;
  localparam logic [7:0] SPEED_REF_RST = 8'h00;
  localparam logic [7:0] MISC_RST      = 8'h00;
  localparam logic [7:0] FAST_BASE_RST = 8'h00;
  localparam int REGION_LO = 16;
  localparam logic [31:0] REGION_ZERO_MASK = 32'hA300_0000;

  // ---------------------------------------------------------------
  // Divider half periods, in source rising edges
  // ---------------------------------------------------------------
  typedef logic [2:0] half_t;
  localparam half_t HALF_DIV2  = 3'h1;
  localparam half_t HALF_DIV4  = 3'h2;
  localparam half_t HALF_DIV6  = 3'h3;
  localparam half_t HALF_DIV8  = 3'h4;
  localparam half_t HALF_DIV12 = 3'h6;

  typedef enum logic {MODE_FULL = 1'b0, MODE_SLOW = 1'b1} cpu_mode_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CPU_RESET_NS     = 1000000;
  localparam int CPU_RESET_CYCLES =
    (CPU_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic half_t div_2to8(input logic [1:0] code);
    case (code)
      2'h0:    return HALF_DIV2;
      2'h1:    return HALF_DIV4;
      2'h2:    return HALF_DIV6;
      default: return HALF_DIV8;
    endcase
  endfunction

  function automatic half_t div_4to12(input logic [1:0] code);
    case (code)
      2'h0:    return HALF_DIV4;
      2'h1:    return HALF_DIV6;
      2'h2:    return HALF_DIV8;
      default: return HALF_DIV12;
    endcase
  endfunction

endpackage

// *** hw/div_if.sv ***
interface div_if;
  logic                 src_rise;
  clk_gen_pkg::half_t   half_count;
  logic                 clk_out;
  modport core (input src_rise, input half_count, output clk_out);
  modport ctl  (output src_rise, output half_count, input clk_out);
endinterface

// *** hw/edge_divider.sv ***
module edge_divider (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  div_if.core       link
);

  clk_gen_pkg::half_t cnt_q, cnt_d;
  clk_gen_pkg::half_t half_q, half_d;
  logic               out_q, out_d;

  // ---------------------------------------------------------------
  // Toggle every half period; new divisor only at a toggle
  // ---------------------------------------------------------------
  always_comb
  begin
    cnt_d  = cnt_q;
    half_d = half_q;
    out_d  = out_q;
    if (link.src_rise)
    begin
      if (cnt_q + 3'h1 >= half_q)
      begin
        cnt_d  = '0;
        out_d  = ~out_q;
        half_d = link.half_count;  // see [RULE25]
      end
      else
      begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q  <= '0;
      half_q <= clk_gen_pkg::HALF_DIV2;
      out_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      half_q <= half_d;
      out_q  <= out_d;
    end
  end

  assign link.clk_out = out_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_toggle_on_edge;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(out_q) |-> $past(link.src_rise);
  endproperty
  a_toggle_on_edge: assert property (p_toggle_on_edge) // see [RULE25]
    else $error("Divided clock toggled without a source edge");

  property p_half_at_boundary;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(half_q) |-> $changed(out_q);
  endproperty
  a_half_at_boundary: assert property (p_half_at_boundary) // see [RULE25]
    else $error("Divisor changed away from a clock boundary");

endmodule

// *** hw/cpu_isa_clock_gen.sv ***
// Overview of operation
// [RULE1] After reset the CPU clock is the double-rate crystal divided by two.
// [RULE2] The 14.318 MHz OSC input divided by twelve gives the timer tick.
// [RULE3] With a bus oscillator fitted, SYSCLK always comes from it.
// [RULE4] With bus oscillator, sense bit 0 picks slow divider, 1 fast.
// [RULE5] Enabled fast-region hit forces the fast divider regardless of sense.
// [RULE6] Bus-oscillator slow field codes 00..11 divide by 2, 4, 6, 8.
// [RULE7] Fast field codes 00..11 divide by 2, 4, 6, 8 in both modes.
// [RULE8] Without bus oscillator, SYSCLK comes from the double-rate crystal.
// [RULE9] Without oscillator, board drives the pin low for slow, high fast.
// [RULE10] Without oscillator, sense bit ignores writes and reads the pin.
// [RULE11] Crystal-mode slow field codes 00..11 divide by 4, 6, 8, 12.
// [RULE12] Region hit needs A23-A16 equal base and A31,A29,A25,A24 zero.
// [RULE13] Bus-master and DMA accesses never force the fast divider.
// [RULE14] Reset sets fast and slow divider fields to 11.
// [RULE15] With bus oscillator, reset clears the sense bit.
// [RULE16] Reset clears the region enable and the region base register.
// [RULE17] Port F4h write with soft speed bit 0 enters slow CPU mode.
// [RULE18] Port F5h write returns the CPU clock to crystal divided by two.
// [RULE19] Each CPU frequency change issues a 1 ms CPU-only reset first.
// [RULE20] With CPU divider 00, F4h and F5h writes cause no reset.
// [RULE21] Speed switch pin leaves clock alone, reads at bit 4.
// [RULE22] Slot clock stays crystal divided by two in every mode.
// [RULE23] CPU divider field resets to 00, full speed.
// [RULE24] Bus oscillator presence is a strap caught after reset.
// [RULE25] Divider changes take effect only at clock boundaries.
module cpu_isa_clock_gen #(
  parameter int unsigned CPU_RESET_CYCLES = clk_gen_pkg::CPU_RESET_CYCLES
) (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cpu_double_rate_crystal_i,
  input  wire logic        bus_oscillator_in_i,
  input  wire logic        osc_i,
  input  wire logic        bus_osc_present_i,
  input  wire logic        speed_switch_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_ack_o,
  input  wire logic        mem_access_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic        master_or_dma_i,
  output logic             cpu_clk_o,
  output logic             cpu_reset_o,
  output logic             isa_sysclk_o,
  output logic             slot_clk_o,
  output logic             timer_tick_o
);

  localparam int RST_W = $clog2(CPU_RESET_CYCLES + 1);
  localparam int N_PIN = 5;
  localparam int P_XTAL = 0;
  localparam int P_BOSC = 1;
  localparam int P_OSC  = 2;
  localparam int P_STRAP = 3;
  localparam int P_SPEED = 4;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [N_PIN-1:0] meta_q, meta_d, sync_q, sync_d, last_q, last_d;
  logic [N_PIN-1:0] rise;

  always_comb
  begin
    meta_d = {speed_switch_i, bus_osc_present_i, osc_i,
              bus_oscillator_in_i, cpu_double_rate_crystal_i};
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign rise = sync_q & ~last_q;

  // ---------------------------------------------------------------
  // Bus oscillator presence strap
  // ---------------------------------------------------------------
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic       present_q, present_d;

  always_comb
  begin
    strap_cnt_d = strap_cnt_q;
    present_d   = present_q;
    if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      present_d   = sync_q[P_STRAP];  // see [RULE24]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      strap_cnt_q <= '0;
      present_q   <= 1'b0;
    end
    else
    begin
      strap_cnt_q <= strap_cnt_d;
      present_q   <= present_d;
    end
  end

  // ---------------------------------------------------------------
  // Register file, CPU mode and CPU-only reset
  // ---------------------------------------------------------------
  logic [7:0]       idx_q, idx_d;
  logic [7:0]       cfg_q, cfg_d;
  logic [7:0]       spd_q, spd_d;
  logic [7:0]       misc_q, misc_d;
  logic [7:0]       base_q, base_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             ack_q, ack_d;
  clk_gen_pkg::cpu_mode_t mode_q, mode_d;
  logic [RST_W-1:0] rst_cnt_q, rst_cnt_d;
  logic             cpu_rst_q, cpu_rst_d;
  logic [1:0]       cpu_div;
  logic             sense_eff, change;
  logic             wr_data, wr_slow, wr_full;

  assign cpu_div = cfg_q[clk_gen_pkg::CPU_DIV_LO +: 2];
  assign sense_eff = present_q ? cfg_q[clk_gen_pkg::SENSE_BIT]
                               : sync_q[P_BOSC];  // see [RULE10]
  assign wr_data = io_wr_i && (io_addr_i == clk_gen_pkg::DATA_PORT);
  assign wr_slow = io_wr_i && (io_addr_i == clk_gen_pkg::SLOW_PORT);
  assign wr_full = io_wr_i && (io_addr_i == clk_gen_pkg::FULL_PORT);

  always_comb
  begin
    idx_d   = idx_q;
    cfg_d   = cfg_q;
    spd_d   = spd_q;
    misc_d  = misc_q;
    base_d  = base_q;
    mode_d  = mode_q;
    rdata_d = rdata_q;
    ack_d   = io_wr_i || io_rd_i;
    change  = 1'b0;
    if (io_wr_i && (io_addr_i == clk_gen_pkg::IDX_PORT))
    begin
      idx_d = io_wdata_i;
    end
    else if (wr_data && (idx_q == clk_gen_pkg::IDX_CLK_CFG))
    begin
      cfg_d = io_wdata_i;
      if (!present_q)
      begin
        cfg_d[clk_gen_pkg::SENSE_BIT] =
          cfg_q[clk_gen_pkg::SENSE_BIT];  // see [RULE10]
      end
      change = (mode_q == clk_gen_pkg::MODE_SLOW) &&
               (io_wdata_i[clk_gen_pkg::CPU_DIV_LO +: 2] !=
                cpu_div);  // see [RULE19]
    end
    else if (wr_data && (idx_q == clk_gen_pkg::IDX_SPEED_REF))
    begin
      spd_d = io_wdata_i;
    end
    else if (wr_data && (idx_q == clk_gen_pkg::IDX_MISC))
    begin
      misc_d = io_wdata_i;
    end
    else if (wr_data && (idx_q == clk_gen_pkg::IDX_FAST_BASE))
    begin
      base_d = io_wdata_i;
    end
    else if (wr_slow && !misc_q[clk_gen_pkg::SOFT_SPEED_BIT])
    begin
      mode_d = clk_gen_pkg::MODE_SLOW;  // see [RULE17]
      change = (mode_q == clk_gen_pkg::MODE_FULL) &&
               (cpu_div != 2'h0);  // see [RULE20]
    end
    else if (wr_full)
    begin
      mode_d = clk_gen_pkg::MODE_FULL;  // see [RULE18]
      change = (mode_q == clk_gen_pkg::MODE_SLOW) &&
               (cpu_div != 2'h0);  // see [RULE20]
    end
    if (io_rd_i && (io_addr_i == clk_gen_pkg::IDX_PORT))
    begin
      rdata_d = idx_q;
    end
    else if (io_rd_i && (io_addr_i == clk_gen_pkg::DATA_PORT))
    begin
      if (idx_q == clk_gen_pkg::IDX_CLK_CFG)
      begin
        rdata_d = cfg_q;
        rdata_d[clk_gen_pkg::SENSE_BIT] = sense_eff;
      end
      else if (idx_q == clk_gen_pkg::IDX_SPEED_REF)
      begin
        rdata_d = spd_q;
        rdata_d[clk_gen_pkg::SPEED_SW_BIT] =
          sync_q[P_SPEED];  // see [RULE21]
      end
      else if (idx_q == clk_gen_pkg::IDX_MISC)
      begin
        rdata_d = misc_q;
      end
      else if (idx_q == clk_gen_pkg::IDX_FAST_BASE)
      begin
        rdata_d = base_q;
      end
      else
      begin
        rdata_d = '0;
      end
    end
    else if (io_rd_i)
    begin
      rdata_d = '0;
    end
    // Reset begins at the acknowledge edge, before the divider moves
    if (change)
    begin
      rst_cnt_d = RST_W'(CPU_RESET_CYCLES);  // see [RULE19]
    end
    else if (rst_cnt_q != '0)
    begin
      rst_cnt_d = rst_cnt_q - RST_W'(1);
    end
    else
    begin
      rst_cnt_d = rst_cnt_q;
    end
    cpu_rst_d = (rst_cnt_d != '0);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      idx_q     <= '0;
      cfg_q     <= clk_gen_pkg::CLK_CFG_RST;  // see [RULE14] [RULE15] [RULE16] [RULE23]
      spd_q     <= clk_gen_pkg::SPEED_REF_RST;
      misc_q    <= clk_gen_pkg::MISC_RST;
      base_q    <= clk_gen_pkg::FAST_BASE_RST;  // see [RULE16]
      mode_q    <= clk_gen_pkg::MODE_FULL;  // see [RULE1]
      rdata_q   <= '0;
      ack_q     <= 1'b0;
      rst_cnt_q <= '0;
      cpu_rst_q <= 1'b0;
    end
    else
    begin
      idx_q     <= idx_d;
      cfg_q     <= cfg_d;
      spd_q     <= spd_d;
      misc_q    <= misc_d;
      base_q    <= base_d;
      mode_q    <= mode_d;
      rdata_q   <= rdata_d;
      ack_q     <= ack_d;
      rst_cnt_q <= rst_cnt_d;
      cpu_rst_q <= cpu_rst_d;
    end
  end

  assign io_rdata_o  = rdata_q;
  assign io_ack_o    = ack_q;
  assign cpu_reset_o = cpu_rst_q;

  // ---------------------------------------------------------------
  // Divider selection
  // ---------------------------------------------------------------
  logic               region_hit, fast_sel;
  clk_gen_pkg::half_t sys_half, cpu_half;

  assign region_hit = mem_access_i && !master_or_dma_i  // see [RULE13]
    && cfg_q[clk_gen_pkg::FAST_EN_BIT]
    && (mem_addr_i[clk_gen_pkg::REGION_LO +: 8] == base_q)  // see [RULE12]
    && ((mem_addr_i & clk_gen_pkg::REGION_ZERO_MASK) == '0);
  assign fast_sel = region_hit || sense_eff;  // see [RULE4] [RULE5]

  always_comb
  begin
    if (fast_sel)
    begin
      sys_half = clk_gen_pkg::div_2to8(
        cfg_q[clk_gen_pkg::FAST_DIV_LO +: 2]);  // see [RULE7]
    end
    else if (present_q)
    begin
      sys_half = clk_gen_pkg::div_2to8(
        cfg_q[clk_gen_pkg::SLOW_DIV_LO +: 2]);  // see [RULE6]
    end
    else
    begin
      sys_half = clk_gen_pkg::div_4to12(
        cfg_q[clk_gen_pkg::SLOW_DIV_LO +: 2]);  // see [RULE11]
    end
    if (mode_q == clk_gen_pkg::MODE_SLOW)
    begin
      cpu_half = clk_gen_pkg::div_2to8(cpu_div);  // see [RULE17]
    end
    else
    begin
      cpu_half = clk_gen_pkg::HALF_DIV2;  // see [RULE1] [RULE18]
    end
  end

  // ---------------------------------------------------------------
  // Divided clocks
  // ---------------------------------------------------------------
  div_if cpu_link ();
  div_if sys_link ();
  div_if slot_link ();
  div_if tick_link ();

  assign cpu_link.src_rise    = rise[P_XTAL];
  assign cpu_link.half_count  = cpu_half;
  assign sys_link.src_rise    = present_q ? rise[P_BOSC]  // see [RULE3]
                                          : rise[P_XTAL];  // see [RULE8]
  assign sys_link.half_count  = sys_half;
  assign slot_link.src_rise   = rise[P_XTAL];
  assign slot_link.half_count = clk_gen_pkg::HALF_DIV2;  // see [RULE22]
  assign tick_link.src_rise   = rise[P_OSC];
  assign tick_link.half_count = clk_gen_pkg::HALF_DIV12;  // see [RULE2]

  edge_divider u_cpu  (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
                       .link(cpu_link.core));
  edge_divider u_sys  (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
                       .link(sys_link.core));
  edge_divider u_slot (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
                       .link(slot_link.core));
  edge_divider u_tick (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
                       .link(tick_link.core));

  assign cpu_clk_o    = cpu_link.clk_out;
  assign isa_sysclk_o = sys_link.clk_out;
  assign slot_clk_o   = slot_link.clk_out;
  assign timer_tick_o = tick_link.clk_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_por_state;
    $fell(sys_rst_i) |-> cfg_q == clk_gen_pkg::CLK_CFG_RST
      && base_q == '0 && mode_q == clk_gen_pkg::MODE_FULL;
  endproperty
  a_por_state: assert property (p_por_state) // see [RULE14]
    else $error("Clock registers not at power-on values");

  property p_f4_reset;
    wr_slow && !misc_q[clk_gen_pkg::SOFT_SPEED_BIT] && cpu_div != 2'h0
      && mode_q == clk_gen_pkg::MODE_FULL
      |=> cpu_reset_o && mode_q == clk_gen_pkg::MODE_SLOW
      ##1 cpu_reset_o [*4];
  endproperty
  a_f4_reset: assert property (p_f4_reset) // see [RULE19]
    else $error("Slow-mode entry did not raise CPU reset");

  property p_no_reset_div0;
    (wr_slow || wr_full) && cpu_div == 2'h0 && rst_cnt_q == '0
      |=> !cpu_reset_o;
  endproperty
  a_no_reset_div0: assert property (p_no_reset_div0) // see [RULE20]
    else $error("CPU reset raised with CPU divider at 00");

  property p_reset_load;
    $rose(cpu_reset_o) |-> rst_cnt_q == RST_W'(CPU_RESET_CYCLES);
  endproperty
  a_reset_load: assert property (p_reset_load) // see [RULE19]
    else $error("CPU reset started with wrong length");

  property p_master_no_hit;
    master_or_dma_i |-> !region_hit;
  endproperty
  a_master_no_hit: assert property (p_master_no_hit) // see [RULE13]
    else $error("Master or DMA access forced the fast divider");

  property p_hit_addr;
    region_hit |-> mem_addr_i[23:16] == base_q && !mem_addr_i[31]
      && !mem_addr_i[29] && !mem_addr_i[25] && !mem_addr_i[24];
  endproperty
  a_hit_addr: assert property (p_hit_addr) // see [RULE12]
    else $error("Region hit on a non-matching address");

  property p_sense_ro;
    wr_data && idx_q == clk_gen_pkg::IDX_CLK_CFG && !present_q
      |=> $stable(cfg_q[clk_gen_pkg::SENSE_BIT]);
  endproperty
  a_sense_ro: assert property (p_sense_ro) // see [RULE10]
    else $error("Sense bit written without bus oscillator");

  property p_fast_forced;
    region_hit |-> sys_half ==
      clk_gen_pkg::div_2to8(cfg_q[clk_gen_pkg::FAST_DIV_LO +: 2]);
  endproperty
  a_fast_forced: assert property (p_fast_forced) // see [RULE5]
    else $error("Region hit did not select the fast divider");

  c_slow_entry: cover property ($rose(cpu_reset_o) &&
    mode_q == clk_gen_pkg::MODE_SLOW);
  c_full_return: cover property ($rose(cpu_reset_o) &&
    mode_q == clk_gen_pkg::MODE_FULL);
  c_region_hit: cover property (region_hit && !sense_eff);

endmodule

// *** tb/far_side.sv ***
module far_side (
  input  wire logic sys_clk_i,
  input  wire logic present_i,
  input  wire logic fast_req_i,
  output logic      xtal_o,
  output logic      bosc_o,
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // Free-running board oscillators
  // -------------------------------------------------------------
  int   xc = 0;
  int   bc = 0;
  logic bt = 1'b0;
  initial
  begin
    xtal_o = 1'b0;
    osc_o  = 1'b0;
  end
  always @(posedge sys_clk_i)
  begin
    xc <= (xc == 2) ? 0 : xc + 1;
    bc <= (bc == 3) ? 0 : bc + 1;
    if (xc == 2)
    begin
      xtal_o <= !xtal_o;
      osc_o  <= !osc_o;
    end
    if (bc == 3)
      bt <= !bt;
  end
  // Divider request level when no oscillator is fitted
  assign bosc_o = present_i ? bt : fast_req_i;
endmodule

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 20;
  localparam int XP = 6;
  localparam int BP = 8;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        xtal, bosc, osc, fast_req = 1'b0;
  logic        bus_osc_present_i = 1'b1;
  logic        speed_switch_i = 1'b0;
  logic [15:0] io_addr_i = 16'h0000;
  logic [7:0]  io_wdata_i = 8'h00;
  logic        io_wr_i = 1'b0;
  logic        io_rd_i = 1'b0;
  logic [7:0]  io_rdata_o;
  logic        io_ack_o, cpu_clk_o, cpu_reset_o, isa_sysclk_o;
  logic        slot_clk_o, timer_tick_o;
  logic        mem_access_i = 1'b0;
  logic [31:0] mem_addr_i = 32'h0000_0000;
  logic        master_or_dma_i = 1'b0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          per_q[$];
  int          rst_q[$];
  logic [31:0] rd_q[$];
  logic        rdp = 1'b0, arm = 1'b0, rp = 1'b0, pv = 1'b0, cur;
  int          sel = 0, nr = 0, pc = 0, rw = 0, i;
  integer      seed = 32'h5C0A;

  far_side u_far (.sys_clk_i(sys_clk_i), .present_i(bus_osc_present_i),
    .fast_req_i(fast_req), .xtal_o(xtal), .bosc_o(bosc), .osc_o(osc));

  cpu_isa_clock_gen #(.CPU_RESET_CYCLES(RC)) dut_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cpu_double_rate_crystal_i(xtal), .bus_oscillator_in_i(bosc),
    .osc_i(osc), .bus_osc_present_i(bus_osc_present_i),
    .speed_switch_i(speed_switch_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_rdata_o(io_rdata_o), .io_ack_o(io_ack_o),
    .mem_access_i(mem_access_i), .mem_addr_i(mem_addr_i),
    .master_or_dma_i(master_or_dma_i), .cpu_clk_o(cpu_clk_o),
    .cpu_reset_o(cpu_reset_o), .isa_sysclk_o(isa_sysclk_o),
    .slot_clk_o(slot_clk_o), .timer_tick_o(timer_tick_o));

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic io(input logic [15:0] a, input logic [7:0] d,
                    input logic r);
    int n;
    n = 0;
    io_addr_i  <= a;
    io_wdata_i <= d;
    io_wr_i    <= !r;
    io_rd_i    <= r;
    @(posedge sys_clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end
    while (io_ack_o !== 1'b1 && n < 4);
    if (n == 4)
      chk("io_ack_o", 32'h1, 32'h0);
    @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    io(clk_gen_pkg::IDX_PORT, x, 1'b0);
    io(clk_gen_pkg::DATA_PORT, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] x, input logic [7:0] e);
    io(clk_gen_pkg::IDX_PORT, x, 1'b0);
    rd_q.push_back({24'h0, e});
    rdp = 1'b1;
    io(clk_gen_pkg::DATA_PORT, 8'($random(seed)), 1'b1);
  endtask

  task automatic per(input int s, input int p);
    per_q.push_back(p);
    sel = s;
    nr  = 0;
    arm = 1'b1;
    while (arm)
      @(posedge sys_clk_i);
  endtask

  task automatic do_rst(input logic s);
    sys_rst_i         <= 1'b1;
    bus_osc_present_i <= s;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
  endtask

  // -------------------------------------------------------------
  // Output watcher
  // -------------------------------------------------------------
  initial
  forever
  begin
    @(negedge sys_clk_i);
    if (io_ack_o === 1'b1 && rdp)
    begin
      chk("io_rdata_o", rd_q.pop_front(), {24'h0, io_rdata_o});
      rdp = 1'b0;
    end
    if (cpu_reset_o === 1'b1)
      rw++;
    else if (rp)
    begin
      chk("cpu_reset_o width", rst_q.size() ? rst_q.pop_front() : 0,
          rw);
      rw = 0;
    end
    rp  = (cpu_reset_o === 1'b1);
    cur = sel == 0 ? cpu_clk_o : sel == 1 ? isa_sysclk_o :
          sel == 2 ? slot_clk_o : timer_tick_o;
    if (arm && cur === 1'b1 && pv === 1'b0)
    begin
      nr++;
      if (nr == 3)
      begin
        chk($sformatf("period of output %0d", sel), per_q.pop_front(), pc);
        arm = 1'b0;
      end
      pc = 0;
    end
    pc++;
    pv = cur;
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    fail_count++;
    $display("Error timeout expected end seen hang");
    wrap_up;
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial
  begin
    do_rst(1'b1);
    rd(clk_gen_pkg::IDX_CLK_CFG, 8'h1B);
    rd(clk_gen_pkg::IDX_FAST_BASE, 8'h00);
    per(0, 2 * XP);
    per(1, 8 * BP);
    per(3, 12 * XP);
    for (i = 0; i < 4; i++)
    begin
      wr(clk_gen_pkg::IDX_CLK_CFG, 8'(8'h18 + i));
      per(1, (2 * i + 2) * BP);
      wr(clk_gen_pkg::IDX_CLK_CFG, 8'(8'h07 + 8 * i));
      per(1, (2 * i + 2) * BP);
    end
    wr(clk_gen_pkg::IDX_FAST_BASE, 8'h5A);
    wr(clk_gen_pkg::IDX_CLK_CFG, 8'h83);
    rd(clk_gen_pkg::IDX_FAST_BASE, 8'h5A);
    mem_access_i <= 1'b1;
    mem_addr_i   <= {16'h005A, 16'($random(seed))};
    per(1, 2 * BP);
    mem_addr_i[29] <= 1'b1;
    per(1, 8 * BP);
    mem_addr_i[29]  <= 1'b0;
    master_or_dma_i <= 1'b1;
    per(1, 8 * BP);
    master_or_dma_i <= 1'b0;
    mem_access_i    <= 1'b0;
    $display("Test bus oscillator and region done");
    do_rst(1'b0);
    rd(clk_gen_pkg::IDX_CLK_CFG, 8'h1B);
    for (i = 0; i < 4; i++)
    begin
      wr(clk_gen_pkg::IDX_CLK_CFG, 8'(8'h1C + i));
      per(1, (i == 3 ? 12 : 2 * i + 4) * XP);
    end
    fast_req <= 1'b1;
    rd(clk_gen_pkg::IDX_CLK_CFG, 8'h1F);
    for (i = 0; i < 4; i++)
    begin
      wr(clk_gen_pkg::IDX_CLK_CFG, 8'(8'h03 + 8 * i));
      per(1, (2 * i + 2) * XP);
    end
    $display("Test crystal source done");
    wr(clk_gen_pkg::IDX_CLK_CFG, 8'h5B);
    rst_q.push_back(RC);
    io(clk_gen_pkg::SLOW_PORT, 8'h00, 1'b0);
    per(0, 6 * XP);
    per(2, 2 * XP);
    rst_q.push_back(RC);
    wr(clk_gen_pkg::IDX_CLK_CFG, 8'h7B);
    per(0, 8 * XP);
    rst_q.push_back(RC);
    io(clk_gen_pkg::FULL_PORT, 8'h00, 1'b0);
    per(0, 2 * XP);
    wr(clk_gen_pkg::IDX_MISC, 8'h80);
    io(clk_gen_pkg::SLOW_PORT, 8'h00, 1'b0);
    per(0, 2 * XP);
    wr(clk_gen_pkg::IDX_MISC, 8'h00);
    wr(clk_gen_pkg::IDX_CLK_CFG, 8'h1B);
    io(clk_gen_pkg::SLOW_PORT, 8'h00, 1'b0);
    io(clk_gen_pkg::FULL_PORT, 8'h00, 1'b0);
    speed_switch_i <= 1'b1;
    rd(clk_gen_pkg::IDX_SPEED_REF, 8'h10);
    per(0, 2 * XP);
    repeat (40) @(posedge sys_clk_i);
    chk("pending cpu resets", 32'h0, 32'(rst_q.size()));
    $display("Test cpu clock control done");
    wrap_up;
  end
endmodule
